// ==== design/vipc_top.sv ====
// Purpose: Voice FIFO/DMA interrupt sources, interface select and decoder path control
// Assumes: APB slave on ref_clk (40 MHz); event inputs synchronous to ref_clk
// Notes:   Register at index N sits at byte address 4*N; data in bits 7:0
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`include "vipc_defines.svh"

// Notes on behaviour
// (RL1) TX FIFO enables: empty bit7, full bit6
// (RL2) RX FIFO enables: empty bit7, full bit6
// (RL3) DMA enables: TX done bit4, RX bit0
// (RL4) TX empty flag sets on enable and condition
// (RL5) Flags stay set until software clears them
// (RL6) Flags share bit positions with their enables
// (RL7) Bits 6:5 pick I2S, SPI, UART0, UART1
// (RL8) Software writes zero to unused bits
// (RL9) Mute bit sends mute values instead
// (RL10) Init bit resets the byte splitter
// (RL11) Split bit sends high byte then low
// (RL12) Other flags set on enabled event; irq
module vipc_top (
  input  wire logic                      ref_clk,
  input  wire logic                      resetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [`VIPC_ADDR_W-1:0]   paddr,
  input  wire logic [31:0]               pwdata,
  output logic                           pready,
  output logic [31:0]                    prdata,
  output logic                           pslverr,
  input  wire vipc_pkg::vipc_events_s    events,
  output logic                           irq,
  input  wire logic                      dec_valid,
  input  wire logic [15:0]               dec_data,
  output logic                           dec_ready,
  output logic                           if_valid,
  output logic [15:0]                    if_data,
  output vipc_pkg::vipc_if_e             if_select,
  input  wire logic [3:0]                if_ready
);

  logic [7:0]           tx_fifo_irq_en_reg_ff;
  logic [7:0]           rx_fifo_irq_en_reg_ff;
  logic [7:0]           dma_irq_en_reg_ff;
  logic [7:0]           tx_fifo_irq_src_reg_ff;
  logic [7:0]           rx_fifo_irq_src_reg_ff;
  logic [7:0]           dma_irq_src_reg_ff;
  logic [7:0]           tx_fifo_condition_reg_ff;
  logic [7:0]           interface_select_reg_ff;
  logic [7:0]           mute_value_high_ff;
  logic [7:0]           mute_value_low_ff;
  vipc_pkg::vipc_path_s path_ff;

  logic [7:0]           nxt_tx_src;
  logic [7:0]           nxt_rx_src;
  logic [7:0]           nxt_dma_src;
  logic [7:0]           tx_set;
  logic [7:0]           rx_set;
  logic [7:0]           dma_set;
  logic                 wr_en;
  logic                 setup;
  logic [7:0]           wbyte;
  logic [7:0]           rd_byte;
  logic                 rd_hit;
  logic                 split_word_ready;
  logic [15:0]          path_word;
  logic                 sel_ready;

  // True when paddr is the aligned byte address of register index idx
  function automatic logic hit(input logic [`VIPC_ADDR_W-1:0] addr,
                               input logic [`VIPC_IDX_W-1:0]  idx);
    hit = (addr[1:0] == 2'h0) && (addr[`VIPC_ADDR_W-1:2] == idx);
  endfunction : hit

  // Write-one-to-clear with set winning over a same-cycle clear
  function automatic logic [7:0] w1c(input logic [7:0] cur,
                                     input logic [7:0] set,
                                     input logic       clr_en,
                                     input logic [7:0] clr,
                                     input logic [7:0] mask);
    logic [7:0] keep;
    keep = clr_en ? (cur & ~clr) : cur;
    w1c  = (keep | set) & mask;
  endfunction : w1c

  // Enable value that the coming edge will hold
  function automatic logic [7:0] en_next(input logic [7:0] cur,
                                         input logic       wr,
                                         input logic [7:0] wd,
                                         input logic [7:0] mask);
    en_next = wr ? (wd & mask) : cur;
  endfunction : en_next

  assign setup   = psel && !penable;
  assign wr_en   = psel && penable && pready && pwrite;
  assign wbyte   = pwdata[7:0];

  // APB answer: pready rises in the first access cycle, so each access takes two cycles
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pready <= 1'b0;
    end
    else
    begin
      pready <= setup;
    end
  end

  always_comb
  begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    if (hit(paddr, `VIPC_IDX_TX_EN))
      rd_byte = tx_fifo_irq_en_reg_ff;
    else if (hit(paddr, `VIPC_IDX_RX_EN))
      rd_byte = rx_fifo_irq_en_reg_ff;
    else if (hit(paddr, `VIPC_IDX_DMA_EN))
      rd_byte = dma_irq_en_reg_ff;
    else if (hit(paddr, `VIPC_IDX_TX_SRC))
      rd_byte = tx_fifo_irq_src_reg_ff;
    else if (hit(paddr, `VIPC_IDX_RX_SRC))
      rd_byte = rx_fifo_irq_src_reg_ff;
    else if (hit(paddr, `VIPC_IDX_DMA_SRC))
      rd_byte = dma_irq_src_reg_ff;
    else if (hit(paddr, `VIPC_IDX_TX_COND))
      rd_byte = tx_fifo_condition_reg_ff;
    else if (hit(paddr, `VIPC_IDX_IF_SEL))
      rd_byte = interface_select_reg_ff;
    else if (hit(paddr, `VIPC_IDX_MUTE_HI))
      rd_byte = mute_value_high_ff;
    else if (hit(paddr, `VIPC_IDX_MUTE_LO))
      rd_byte = mute_value_low_ff;
    else if (hit(paddr, `VIPC_IDX_PATH_CTL))
      rd_byte = {1'b0, path_ff.decoder_mute_insert, path_ff.decoder_split_init,
                 path_ff.decoder_byte_split, 4'h0};
    else
      rd_hit = 1'b0;
  end

  // Read data and error are captured in setup and held through the access
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      prdata  <= (pwrite || !rd_hit) ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      pslverr <= !rd_hit;
    end
    else
    begin
      // One-cycle answer: an error left standing would outlive pready
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // (RL1) TX FIFO enables
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      tx_fifo_irq_en_reg_ff <= `VIPC_RST_REG;
    else if (wr_en && hit(paddr, `VIPC_IDX_TX_EN))
      tx_fifo_irq_en_reg_ff <= wbyte & `VIPC_FIFO_MASK;
  end

  // (RL2) RX FIFO enables
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      rx_fifo_irq_en_reg_ff <= `VIPC_RST_REG;
    else if (wr_en && hit(paddr, `VIPC_IDX_RX_EN))
      rx_fifo_irq_en_reg_ff <= wbyte & `VIPC_FIFO_MASK;
  end

  // (RL3) DMA completion enables
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      dma_irq_en_reg_ff <= `VIPC_RST_REG;
    else if (wr_en && hit(paddr, `VIPC_IDX_DMA_EN))
      dma_irq_en_reg_ff <= wbyte & `VIPC_DMA_MASK;
  end

  // TX FIFO condition value mirrors the live FIFO levels
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      tx_fifo_condition_reg_ff <= `VIPC_RST_REG;
    else
    begin
      tx_fifo_condition_reg_ff <= 8'h00;
      tx_fifo_condition_reg_ff[`VIPC_BIT_EMPTY] <= events.tx_empty;
      tx_fifo_condition_reg_ff[`VIPC_BIT_FULL]  <= events.tx_full;
    end
  end

  always_comb
  begin
    tx_set = 8'h00;
    rx_set = 8'h00;
    dma_set = 8'h00;
    // (RL4) TX empty needs enable and condition value
    tx_set[`VIPC_BIT_EMPTY] = tx_fifo_irq_en_reg_ff[`VIPC_BIT_EMPTY]
                              && tx_fifo_condition_reg_ff[`VIPC_BIT_EMPTY];
    // (RL12) Remaining flags on enabled events
    tx_set[`VIPC_BIT_FULL]    = tx_fifo_irq_en_reg_ff[`VIPC_BIT_FULL]
                                && tx_fifo_condition_reg_ff[`VIPC_BIT_FULL];
    rx_set[`VIPC_BIT_EMPTY]   = rx_fifo_irq_en_reg_ff[`VIPC_BIT_EMPTY] && events.rx_empty;
    rx_set[`VIPC_BIT_FULL]    = rx_fifo_irq_en_reg_ff[`VIPC_BIT_FULL] && events.rx_full;
    dma_set[`VIPC_BIT_TX_DONE] = dma_irq_en_reg_ff[`VIPC_BIT_TX_DONE]
                                 && events.tx_dma_complete;
    dma_set[`VIPC_BIT_RX_DONE] = dma_irq_en_reg_ff[`VIPC_BIT_RX_DONE]
                                 && events.rx_dma_complete;
  end

  // (RL5) Sticky, cleared only by software write
  always_comb
  begin
    nxt_tx_src  = w1c(tx_fifo_irq_src_reg_ff, tx_set,
                      wr_en && hit(paddr, `VIPC_IDX_TX_SRC), wbyte, `VIPC_FIFO_MASK);
    nxt_rx_src  = w1c(rx_fifo_irq_src_reg_ff, rx_set,
                      wr_en && hit(paddr, `VIPC_IDX_RX_SRC), wbyte, `VIPC_FIFO_MASK);
    nxt_dma_src = w1c(dma_irq_src_reg_ff, dma_set,
                      wr_en && hit(paddr, `VIPC_IDX_DMA_SRC), wbyte, `VIPC_DMA_MASK);
  end

  // (RL6) Flags at enable bit positions
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_fifo_irq_src_reg_ff <= `VIPC_RST_REG;
      rx_fifo_irq_src_reg_ff <= `VIPC_RST_REG;
      dma_irq_src_reg_ff     <= `VIPC_RST_REG;
    end
    else
    begin
      tx_fifo_irq_src_reg_ff <= nxt_tx_src;
      rx_fifo_irq_src_reg_ff <= nxt_rx_src;
      dma_irq_src_reg_ff     <= nxt_dma_src;
    end
  end

  // (RL12) Level request while an enabled flag is set; enables double as the mask
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      irq <= 1'b0;
    else
      // Next enables too, so an enable write moves irq on the same edge as a clear
      irq <= |(nxt_tx_src & en_next(tx_fifo_irq_en_reg_ff,
                                    wr_en && hit(paddr, `VIPC_IDX_TX_EN),
                                    wbyte, `VIPC_FIFO_MASK))
             || |(nxt_rx_src & en_next(rx_fifo_irq_en_reg_ff,
                                       wr_en && hit(paddr, `VIPC_IDX_RX_EN),
                                       wbyte, `VIPC_FIFO_MASK))
             || |(nxt_dma_src & en_next(dma_irq_en_reg_ff,
                                        wr_en && hit(paddr, `VIPC_IDX_DMA_EN),
                                        wbyte, `VIPC_DMA_MASK));
  end

  // (RL7) Interface select field; (RL8) other bits held at zero
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      interface_select_reg_ff <= `VIPC_RST_REG;
    else if (wr_en && hit(paddr, `VIPC_IDX_IF_SEL))
      interface_select_reg_ff <= wbyte & `VIPC_SEL_MASK;
  end

  // (RL7) Registered select drives routing
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      if_select <= vipc_pkg::VIPC_IF_I2S;
    else
      if_select <= vipc_pkg::vipc_if_e'(
        interface_select_reg_ff[`VIPC_SEL_MSB:`VIPC_SEL_LSB]);
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mute_value_high_ff <= `VIPC_RST_REG;
      mute_value_low_ff  <= `VIPC_RST_REG;
    end
    else
    begin
      if (wr_en && hit(paddr, `VIPC_IDX_MUTE_HI))
        mute_value_high_ff <= wbyte;
      if (wr_en && hit(paddr, `VIPC_IDX_MUTE_LO))
        mute_value_low_ff <= wbyte;
    end
  end

  // Path control fields
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      path_ff <= '0;
    else if (wr_en && hit(paddr, `VIPC_IDX_PATH_CTL))
    begin
      path_ff.decoder_mute_insert <= wbyte[`VIPC_BIT_MUTE];
      path_ff.decoder_split_init  <= wbyte[`VIPC_BIT_INIT];
      path_ff.decoder_byte_split  <= wbyte[`VIPC_BIT_SPLIT];
    end
  end

  // (RL9) Mute values replace decoder words; decoder keeps draining meanwhile
  assign path_word = path_ff.decoder_mute_insert ? {mute_value_high_ff, mute_value_low_ff}
                                                 : dec_data;
  assign dec_ready = split_word_ready;

  // Ready of the selected interface only
  assign sel_ready = if_ready[if_select];

  vipc_byte_split u_split (
    .ref_clk    (ref_clk),
    .resetn     (resetn),
    .init       (path_ff.decoder_split_init),
    .split_en   (path_ff.decoder_byte_split),
    .word_valid (dec_valid),
    .word       (path_word),
    .word_ready (split_word_ready),
    .out_valid  (if_valid),
    .out_data   (if_data),
    .out_ready  (sel_ready)
  );

endmodule : vipc_top

// ==== pkg/vipc_defines.svh ====
// Purpose: Register indices, field positions, reset values for voice irq/path control
// Assumes: Byte address of a register is four times its index
// Notes:   Included by the top design file, the assertions and the bench; not by the package
`ifndef VIPC_DEFINES_SVH
`define VIPC_DEFINES_SVH

`define VIPC_ADDR_W          16
`define VIPC_IDX_W           14

`define VIPC_IDX_TX_EN       14'h2770
`define VIPC_IDX_RX_EN       14'h2771
`define VIPC_IDX_DMA_EN      14'h2772
`define VIPC_IDX_TX_SRC      14'h2773
`define VIPC_IDX_RX_SRC      14'h2774
`define VIPC_IDX_DMA_SRC     14'h2775
`define VIPC_IDX_TX_COND     14'h2776
`define VIPC_IDX_IF_SEL      14'h277A
`define VIPC_IDX_MUTE_HI     14'h277C
`define VIPC_IDX_MUTE_LO     14'h277D
`define VIPC_IDX_PATH_CTL    14'h277E

`define VIPC_BIT_EMPTY       7
`define VIPC_BIT_FULL        6
`define VIPC_BIT_TX_DONE     4
`define VIPC_BIT_RX_DONE     0
`define VIPC_FIFO_MASK       8'hC0
`define VIPC_DMA_MASK        8'h11

`define VIPC_SEL_LSB         5
`define VIPC_SEL_MSB         6
`define VIPC_SEL_MASK        8'h60

`define VIPC_BIT_MUTE        6
`define VIPC_BIT_INIT        5
`define VIPC_BIT_SPLIT       4
`define VIPC_PATH_MASK       8'h70

`define VIPC_RST_REG         8'h00

`endif

// ==== pkg/vipc_pkg.sv ====
// Purpose: Types shared by the voice irq/path control design files
// Assumes: Field layouts come from vipc_defines.svh
// Notes:   Nothing here is imported; users write vipc_pkg::name
package vipc_pkg;

  // External interface chosen for codec data
  typedef enum logic [1:0] {
    VIPC_IF_I2S   = 2'h0,
    VIPC_IF_SPI   = 2'h1,
    VIPC_IF_UART0 = 2'h2,
    VIPC_IF_UART1 = 2'h3
  } vipc_if_e;

  // Splitter states, one-hot
  typedef enum logic [2:0] {
    VIPC_SP_EMPTY = 3'h1,
    VIPC_SP_HIGH  = 3'h2,
    VIPC_SP_LAST  = 3'h4
  } vipc_sp_e;

  // FIFO and DMA condition inputs
  typedef struct packed {
    logic tx_empty;
    logic tx_full;
    logic rx_empty;
    logic rx_full;
    logic tx_dma_complete;
    logic rx_dma_complete;
  } vipc_events_s;

  // Decoder-side path control fields
  typedef struct packed {
    logic decoder_mute_insert;
    logic decoder_split_init;
    logic decoder_byte_split;
  } vipc_path_s;

endpackage : vipc_pkg

// ==== design/vipc_byte_split.sv ====
// Purpose: Turns decoder words into one 16-bit beat or two byte beats
// Assumes: Consumer takes a beat when out_valid and out_ready are both high
// Notes:   Init clears any word in flight; high byte goes first
`timescale 1ns/1ps
module vipc_byte_split (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        init,
  input  wire logic        split_en,
  input  wire logic        word_valid,
  input  wire logic [15:0] word,
  output logic             word_ready,
  output logic             out_valid,
  output logic [15:0]      out_data,
  input  wire logic        out_ready
);

  vipc_pkg::vipc_sp_e state_ff;
  logic [7:0]         low_ff;

  // One word at a time: a new word is taken only once the last beat left
  assign word_ready = (state_ff == vipc_pkg::VIPC_SP_EMPTY) && !init;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_ff  <= vipc_pkg::VIPC_SP_EMPTY;
      low_ff    <= 8'h00;
      out_valid <= 1'b0;
      out_data  <= 16'h0000;
    end
    // (RL10) Init clears splitter
    else if (init)
    begin
      state_ff  <= vipc_pkg::VIPC_SP_EMPTY;
      low_ff    <= 8'h00;
      out_valid <= 1'b0;
      out_data  <= 16'h0000;
    end
    else
    begin
      unique case (state_ff)
        vipc_pkg::VIPC_SP_EMPTY:
        begin
          if (word_valid)
          begin
            out_valid <= 1'b1;
            low_ff    <= word[7:0];
            // (RL11) High byte first
            if (split_en)
            begin
              out_data <= {8'h00, word[15:8]};
              state_ff <= vipc_pkg::VIPC_SP_HIGH;
            end
            else
            begin
              out_data <= word;
              state_ff <= vipc_pkg::VIPC_SP_LAST;
            end
          end
        end
        vipc_pkg::VIPC_SP_HIGH:
        begin
          // (RL11) Low byte follows
          if (out_ready)
          begin
            out_data <= {8'h00, low_ff};
            state_ff <= vipc_pkg::VIPC_SP_LAST;
          end
        end
        vipc_pkg::VIPC_SP_LAST:
        begin
          if (out_ready)
          begin
            out_valid <= 1'b0;
            state_ff  <= vipc_pkg::VIPC_SP_EMPTY;
          end
        end
      endcase
    end
  end

endmodule : vipc_byte_split

// ==== sim/vipc_top_assertions.sv ====
// Purpose: Port assertions for vipc_top
// Assumes: All inputs sampled on ref_clk
// Notes:   Bound into every vipc_top
`timescale 1ns/1ps
`include "vipc_defines.svh"
module vipc_top_assertions (
  input wire logic                   ref_clk,
  input wire logic                   resetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [15:0]            paddr,
  input wire logic [31:0]            pwdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire vipc_pkg::vipc_events_s events,
  input wire logic                   irq,
  input wire logic                   dec_valid,
  input wire logic                   dec_ready,
  input wire logic                   if_valid,
  input wire logic [15:0]            if_data,
  input wire vipc_pkg::vipc_if_e     if_select,
  input wire logic [3:0]             if_ready
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic wr_acc;
  assign wr_acc = psel && penable && pwrite;
  sequence s_init_wr;
    wr_acc && paddr == {`VIPC_IDX_PATH_CTL, 2'h0} && pwdata[`VIPC_BIT_INIT];
  endsequence
  sequence s_cleared;
    !dec_ready ##1 !if_valid;
  endsequence
  property p_acc; psel && !penable |=> pready; endproperty
  a_acc: assert property (p_acc)
    else $error("no pready in access cycle");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err)
    else $error("pslverr without pready");
  property p_sticky; irq && !wr_acc |=> irq; endproperty
  a_sticky: assert property (p_sticky)
    else $error("irq dropped without a write");
  property p_cause; $rose(irq) |-> |$past(events) || |$past(events, 2) || $past(wr_acc); endproperty
  a_cause: assert property (p_cause)
    else $error("irq rose without cause");
  property p_sel; $changed(if_select) |-> $past(wr_acc && paddr == {`VIPC_IDX_IF_SEL, 2'h0}, 2); endproperty
  a_sel: assert property (p_sel)
    else $error("select changed without write");
  property p_ans; dec_valid && dec_ready |=> if_valid; endproperty
  a_ans: assert property (p_ans)
    else $error("no beat after word taken");
  property p_hold; if_valid && !if_ready[if_select] && !psel && !$past(psel) |=> if_valid && $stable(if_data); endproperty
  a_hold: assert property (p_hold)
    else $error("beat not held while stalled");
  property p_busy; if_valid |-> !dec_ready; endproperty
  a_busy: assert property (p_busy)
    else $error("word taken while beat pending");
  property p_init; s_init_wr |=> s_cleared; endproperty
  a_init: assert property (p_init)
    else $error("init did not clear splitter");
endmodule : vipc_top_assertions

bind vipc_top vipc_top_assertions u_chk (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .events(events), .irq(irq), .dec_valid(dec_valid),
  .dec_ready(dec_ready), .if_valid(if_valid), .if_data(if_data), .if_select(if_select),
  .if_ready(if_ready));

// ==== sim/tb_top.sv ====
// Purpose: Self-checking bench for vipc_top
// Assumes: APB tasks; decoder and consumers driven here
// Notes:   Register model and beat queue checked at every result
`timescale 1ns/1ps
`include "vipc_defines.svh"
module tb_top;
  logic                   ref_clk = 1'b0;
  logic                   resetn = 1'b0;
  logic                   psel = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite = 1'b0;
  logic [15:0]            paddr = 16'h0000;
  logic [31:0]            pwdata = 32'h0000_0000;
  logic                   pready;
  logic [31:0]            prdata;
  logic                   pslverr;
  vipc_pkg::vipc_events_s events = '0;
  logic                   irq;
  logic                   dec_valid = 1'b0;
  logic [15:0]            dec_data = 16'h0000;
  logic                   dec_ready;
  logic                   if_valid;
  logic [15:0]            if_data;
  vipc_pkg::vipc_if_e     if_select;
  logic [3:0]             if_ready = 4'h0;
  integer                 mismatches = 0;
  integer                 num_checks = 0;
  integer                 seed = 59;
  logic                   stall = 1'b1;
  logic [7:0]             m [0:15];
  logic [15:0]            exp_q [$];
  localparam logic [13:0] RD_IDX [10] = '{`VIPC_IDX_TX_EN, `VIPC_IDX_RX_EN, `VIPC_IDX_DMA_EN,
    `VIPC_IDX_TX_SRC, `VIPC_IDX_RX_SRC, `VIPC_IDX_DMA_SRC, `VIPC_IDX_IF_SEL,
    `VIPC_IDX_MUTE_HI, `VIPC_IDX_MUTE_LO, `VIPC_IDX_PATH_CTL};

  vipc_top u_dut (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .events(events), .irq(irq), .dec_valid(dec_valid),
    .dec_data(dec_data), .dec_ready(dec_ready), .if_valid(if_valid), .if_data(if_data),
    .if_select(if_select), .if_ready(if_ready));

  initial
  begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic final_report;
    if (mismatches == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, want);
    end
  endtask : check

  function automatic logic [7:0] wmask(input logic [13:0] idx);
    case (idx)
      `VIPC_IDX_TX_EN, `VIPC_IDX_RX_EN, `VIPC_IDX_TX_SRC, `VIPC_IDX_RX_SRC: wmask = `VIPC_FIFO_MASK;
      `VIPC_IDX_DMA_EN, `VIPC_IDX_DMA_SRC: wmask = `VIPC_DMA_MASK;
      `VIPC_IDX_IF_SEL: wmask = `VIPC_SEL_MASK;
      `VIPC_IDX_PATH_CTL: wmask = `VIPC_PATH_MASK;
      default: wmask = 8'hFF;
    endcase
  endfunction : wmask

  function automatic logic irq_exp();
    irq_exp = |(m[3] & m[0]) || |(m[4] & m[1]) || |(m[5] & m[2]);
  endfunction : irq_exp

  task automatic apb(input logic wr, input logic [13:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h00_0000, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wreg(input logic [13:0] idx, input logic [7:0] wd);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, idx, wd & wmask(idx), rd, err);
    if (idx >= `VIPC_IDX_TX_SRC && idx <= `VIPC_IDX_DMA_SRC)
      m[idx[3:0]] &= ~wd;
    else
      m[idx[3:0]] = wd & wmask(idx);
  endtask : wreg

  task automatic rreg(input logic [13:0] idx);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, idx, 8'h00, rd, err);
    check(rd, {24'h00_0000, m[idx[3:0]]});
    check(32'(err), 32'h0);
  endtask : rreg

  task automatic pulse(input logic [5:0] ev);
    @(posedge ref_clk);
    events <= ev;
    @(posedge ref_clk);
    events <= '0;
    repeat (3) @(posedge ref_clk);
    m[3] |= {ev[5], ev[4], 6'h00} & m[0];
    m[4] |= {ev[3], ev[2], 6'h00} & m[1];
    m[5] |= {3'h0, ev[1], 3'h0, ev[0]} & m[2];
  endtask : pulse

  task automatic send(input logic [15:0] w);
    integer      n;
    logic [15:0] v;
    n = 0;
    @(posedge ref_clk);
    dec_valid <= 1'b1;
    dec_data <= w;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (dec_ready !== 1'b1 && n < 50);
    check(32'(dec_ready), 32'h1);
    dec_valid <= 1'b0;
    v = m[14][6] ? {m[12], m[13]} : w;
    if (m[14][4])
    begin
      exp_q.push_back({8'h00, v[15:8]});
      exp_q.push_back({8'h00, v[7:0]});
    end
    else
      exp_q.push_back(v);
  endtask : send

  task automatic drain;
    integer n;
    n = 0;
    while (exp_q.size() > 0 && n < 300)
    begin
      @(posedge ref_clk);
      n++;
    end
    check(exp_q.size(), 32'h0);
  endtask : drain

  always @(posedge ref_clk)
  begin
    if_ready <= stall ? 4'h0 : 4'($random(seed));
    if (resetn && if_valid === 1'b1 && if_ready[if_select] === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(32'h1, 32'h0);
      else
        check({16'h0000, if_data}, {16'h0000, exp_q.pop_front()});
    end
  end

  initial
  begin
    logic [31:0] rd;
    logic        err;
    integer      i;
    integer      k;
    for (i = 0; i < 16; i++)
      m[i] = 8'h00;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    for (i = 0; i < 10; i++)
      rreg(RD_IDX[i]);
    for (i = 0; i < 10; i++)
      wreg(RD_IDX[i], 8'($random(seed)));
    for (i = 0; i < 10; i++)
      rreg(RD_IDX[i]);
    apb(1'b0, 14'h2779, 8'h00, rd, err);
    check(32'(err), 32'h1);
    check(rd, 32'h0);
    for (i = 0; i < 12; i++)
    begin
      for (k = 0; k < 3; k++)
        wreg(14'(`VIPC_IDX_TX_EN + k), 8'($random(seed)));
      pulse(6'($random(seed)));
      check(32'(irq), 32'(irq_exp()));
      for (k = 3; k < 6; k++)
        rreg(14'(`VIPC_IDX_TX_EN + k));
      for (k = 3; k < 6; k++)
        wreg(14'(`VIPC_IDX_TX_EN + k), 8'($random(seed)));
      @(posedge ref_clk);
      check(32'(irq), 32'(irq_exp()));
    end
    for (i = 0; i < 4; i++)
    begin
      wreg(`VIPC_IDX_IF_SEL, {1'b0, 2'(i), 5'h00});
      repeat (2) @(posedge ref_clk);
      check(32'(if_select), i);
    end
    stall <= 1'b0;
    for (i = 0; i < 16; i++)
    begin
      wreg(`VIPC_IDX_IF_SEL, {1'b0, 2'(i), 5'h00});
      wreg(`VIPC_IDX_MUTE_HI, 8'($random(seed)));
      wreg(`VIPC_IDX_MUTE_LO, 8'($random(seed)));
      wreg(`VIPC_IDX_PATH_CTL, {1'b0, 1'(i >> 2), 1'b0, 1'(i >> 3), 4'h0});
      repeat (3) send(16'($random(seed)));
      drain();
    end
    wreg(`VIPC_IDX_PATH_CTL, 8'h10);
    stall <= 1'b1;
    send(16'hA55A);
    repeat (2) @(posedge ref_clk);
    wreg(`VIPC_IDX_PATH_CTL, 8'h30);
    repeat (2) @(posedge ref_clk);
    check(32'(if_valid), 32'h0);
    check(32'(dec_ready), 32'h0);
    exp_q.delete();
    wreg(`VIPC_IDX_PATH_CTL, 8'h10);
    stall <= 1'b0;
    send(16'h1234);
    drain();
    final_report();
  end

  initial
  begin
    #(25 * 40000);
    mismatches++;
    final_report();
  end
endmodule : tb_top
